// ===== logic/dag_unit.sv
// one address generator: index, modify, length, base sets and page register
`timescale 1ns/100ps
module dag_unit #(
   parameter int IW = dag_pkg::IDX_W,
   parameter int PW = dag_pkg::PAGE_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // context selection
   input wire logic set_sel,
   // register writes
   input wire logic wr_en,
   input wire logic [3:0] wr_target,
   input wire logic [1:0] wr_sel,
   input wire logic [IW-1:0] wr_data,
   input wire logic page_wr,
   input wire logic [PW-1:0] page_data,
   // access request
   input wire logic acc_en,
   input wire logic [3:0] acc_mode,
   input wire logic [1:0] acc_isel,
   input wire logic [1:0] acc_msel,
   input wire logic acc_use_imm,
   input wire logic [dag_pkg::IMM_W-1:0] acc_imm,
   // address out
   output logic [dag_pkg::ADDR_W-1:0] addr,
   output logic addr_valid,
   output logic [PW-1:0] page
);
   localparam int NR = dag_pkg::NREG;
   // index [set][reg]; set 0 primary, set 1 secondary
   logic [IW-1:0] idx_r [2][NR];
   logic [IW-1:0] mod_r [2][NR];
   logic [IW-1:0] len_r [2][NR];
   logic [IW-1:0] base_r [2][NR];
   logic [PW-1:0] page_r [2];

   // wrap a candidate into [base, base+len); len zero means linear
   function automatic logic [IW-1:0] wrap(input logic [IW-1:0] v, input logic [IW-1:0] b,
                                          input logic [IW-1:0] l, input logic [IW-1:0] m);
      logic [IW-1:0] rel;
      rel = v - b;
      wrap = v;
      // modular distance from base also catches a step that runs below address zero
      if (l != '0 && rel >= l)
         wrap = m[IW-1] ? v + l : v - l;
   endfunction

   wire logic [IW-1:0] cur_idx = idx_r[set_sel][acc_isel];
   wire logic [IW-1:0] imm_ext = {{(IW-dag_pkg::IMM_W){acc_imm[dag_pkg::IMM_W-1]}}, acc_imm};
   wire logic [IW-1:0] step = acc_use_imm ? imm_ext : mod_r[set_sel][acc_msel];
   wire logic [IW-1:0] cur_len = len_r[set_sel][acc_isel];
   wire logic [IW-1:0] cur_base = base_r[set_sel][acc_isel];
   // 16-bit sum never carries into page bits
   wire logic [IW-1:0] next_idx = wrap(cur_idx + step, cur_base, cur_len, step);
   wire logic pre = acc_mode == dag_pkg::dag_mode_pre || acc_mode == dag_pkg::dag_mode_pre_noupd;
   wire logic upd = acc_en && (acc_mode == dag_pkg::dag_mode_pre || acc_mode == dag_pkg::dag_mode_post);
   wire logic [IW-1:0] eff_idx = pre ? next_idx : cur_idx;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int s = 0; s < 2; s++) begin
            page_r[s] <= dag_pkg::PAGE_RESET;
            for (int r = 0; r < NR; r++) begin
               idx_r[s][r] <= dag_pkg::IDX_RESET;
               mod_r[s][r] <= dag_pkg::IDX_RESET;
               len_r[s][r] <= dag_pkg::IDX_RESET;
               base_r[s][r] <= dag_pkg::IDX_RESET;
            end
         end
      end else begin
         if (upd)
            idx_r[set_sel][acc_isel] <= next_idx;
         if (wr_en) begin
            // software write wins over an update of the same pointer
            case (wr_target)
               dag_pkg::dag_wr_index: idx_r[set_sel][wr_sel] <= wr_data;
               dag_pkg::dag_wr_modify: mod_r[set_sel][wr_sel] <= wr_data;
               dag_pkg::dag_wr_length: len_r[set_sel][wr_sel] <= wr_data;
               dag_pkg::dag_wr_base: base_r[set_sel][wr_sel] <= wr_data;
               default: ;
            endcase
         end
         if (page_wr)
            page_r[set_sel] <= page_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         addr <= '0;
         addr_valid <= 1'b0;
      end else begin
         addr_valid <= acc_en && acc_mode != dag_pkg::dag_mode_none;
         if (acc_en)
            addr <= {page_r[set_sel], eff_idx};
      end
   end

   assign page = page_r[set_sel];

   a_page_on_top: assert property (@(posedge clock) disable iff (!nrst)
      addr_valid |-> addr[dag_pkg::ADDR_W-1:IW] == $past(page_r[set_sel]))
      else $error("page bits not from page register");
   a_noupd_keeps: assert property (@(posedge clock) disable iff (!nrst)
      (acc_en && acc_mode == dag_pkg::dag_mode_pre_noupd && !wr_en)
      |=> idx_r[$past(set_sel)][$past(acc_isel)] == $past(cur_idx))
      else $error("no-update mode changed pointer");
   a_post_addr: assert property (@(posedge clock) disable iff (!nrst)
      (acc_en && acc_mode == dag_pkg::dag_mode_post) |=> addr[IW-1:0] == $past(cur_idx))
      else $error("post-modify address not old pointer");
   a_wrap_inside: assert property (@(posedge clock) disable iff (!nrst)
      (upd && !wr_en && cur_len != '0 && cur_idx >= cur_base && cur_idx - cur_base < cur_len
       && (step[IW-1] ? (~step + 16'h0001) <= cur_len : step <= cur_len))
      |=> (idx_r[$past(set_sel)][$past(acc_isel)] - $past(cur_base)) < $past(cur_len))
      else $error("wrapped pointer left buffer");
   a_imm_offset: assert property (@(posedge clock) disable iff (!nrst)
      (acc_en && acc_use_imm && acc_mode == dag_pkg::dag_mode_pre_noupd && cur_len == '0)
      |=> addr[IW-1:0] == $past(cur_idx) + IW'($signed($past(acc_imm))))
      else $error("immediate offset not sign extended");
   a_noupd_sum: assert property (@(posedge clock) disable iff (!nrst)
      (acc_en && !acc_use_imm && acc_mode == dag_pkg::dag_mode_pre_noupd && cur_len == '0)
      |=> addr[IW-1:0] == $past(cur_idx) + $past(mod_r[set_sel][acc_msel]))
      else $error("no-update address not pointer plus modify");
endmodule

// ===== logic/dag_pkg.sv
// constants and types shared by the dual address generator
//
// Contract
// - each of the two generators holds four 16-bit pointers, each updatable on an indirect access.
// - an indirect access applies one of four modify registers before or after forming the address.
// - pre- and post-modify may instead use a signed 8-bit immediate offset from the instruction.
// - pre-modify without update forms pointer plus offset and leaves the pointer unchanged.
// - each pointer has a length and base; updates wrap modulo the length inside the buffer.
// - circular addressing stays within one 64K-word page chosen by the page register of 256.
// - wrapping touches only the low 16 address bits; the page bits are never altered.
// - a full secondary register copy exists and selecting it switches context with no save.
// - both generators can produce an address in the same cycle, data side and program side.
// - the address is the 8-bit page register above the 16-bit index, 24 bits in all.
package dag_pkg;
   localparam int IDX_W = 16;
   localparam int PAGE_W = 8;
   localparam int ADDR_W = 24;
   localparam int IMM_W = 8;
   localparam int NREG = 4;
   localparam int SEL_W = 2;
   localparam logic [15:0] IDX_RESET = 16'h0000;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // register file targets for a write
   typedef enum logic [3:0] {
      dag_wr_index = 4'h1,
      dag_wr_modify = 4'h2,
      dag_wr_length = 4'h4,
      dag_wr_base = 4'h8
   } dag_wr_type;

   // access modes, one-hot
   typedef enum logic [3:0] {
      dag_mode_post = 4'h1,
      dag_mode_pre = 4'h2,
      dag_mode_pre_noupd = 4'h4,
      dag_mode_none = 4'h8
   } dag_mode_type;
endpackage

// ===== logic/dag_top.sv
// pair of address generators with shared context selection
`timescale 1ns/100ps
module dag_top (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // context switch request from decode
   input wire logic ctx_wr,
   input wire logic ctx_secondary,
   // register writes, per generator
   input wire logic [1:0] wr_en,
   input wire logic [7:0] wr_target,
   input wire logic [3:0] wr_sel,
   input wire logic [31:0] wr_data,
   input wire logic [1:0] page_wr,
   input wire logic [15:0] page_data,
   // access requests, generator 0 data side, generator 1 program side
   input wire logic [1:0] acc_en,
   input wire logic [7:0] acc_mode,
   input wire logic [3:0] acc_isel,
   input wire logic [3:0] acc_msel,
   input wire logic [1:0] acc_use_imm,
   input wire logic [15:0] acc_imm,
   // addresses and status
   output logic [23:0] dm_addr,
   output logic dm_addr_valid,
   output logic [23:0] pm_addr,
   output logic pm_addr_valid,
   output logic set_active
);
   logic set_sel;
   logic [23:0] a [2];
   logic v [2];

   always_ff @(posedge clock) begin
      if (!nrst)
         set_sel <= 1'b0;
      else if (ctx_wr)
         set_sel <= ctx_secondary;
   end
   assign set_active = set_sel;

   // both units run every cycle for dual operand fetch
   for (genvar g = 0; g < 2; g++) begin : gen_u
      dag_unit u (
         .clock(clock), .nrst(nrst), .set_sel(set_sel),
         .wr_en(wr_en[g]), .wr_target(wr_target[4*g+:4]), .wr_sel(wr_sel[2*g+:2]),
         .wr_data(wr_data[16*g+:16]), .page_wr(page_wr[g]), .page_data(page_data[8*g+:8]),
         .acc_en(acc_en[g]), .acc_mode(acc_mode[4*g+:4]), .acc_isel(acc_isel[2*g+:2]),
         .acc_msel(acc_msel[2*g+:2]), .acc_use_imm(acc_use_imm[g]), .acc_imm(acc_imm[8*g+:8]),
         .addr(a[g]), .addr_valid(v[g]), .page()
      );
   end
   assign dm_addr = a[0];
   assign dm_addr_valid = v[0];
   assign pm_addr = a[1];
   assign pm_addr_valid = v[1];

   a_ctx_next: assert property (@(posedge clock) disable iff (!nrst)
      ctx_wr |=> set_sel == $past(ctx_secondary))
      else $error("context select late");
endmodule

// ===== bench/dag_bus_sink.sv
// memory-bus side model: counts address pulses seen on both buses
`timescale 1ns/100ps
module dag_bus_sink (
   // clock
   input wire logic clock,
   // address strobes
   input wire logic dm_addr_valid,
   input wire logic pm_addr_valid,
   // pulses seen
   output logic [7:0] pulses
);
   initial pulses = 8'h00;
   // a strobe is counted once in every cycle it is held high, so stretching shows up
   always @(posedge clock) begin
      pulses <= pulses + 8'(dm_addr_valid === 1'b1) + 8'(pm_addr_valid === 1'b1);
   end
endmodule

// ===== bench/tb_dual_data_address_generator.sv
// self-checking bench for the dual address generator
`timescale 1ns/100ps
module tb_dual_data_address_generator;
   logic clock = 0, nrst = 0, ctx_wr = 0, ctx_secondary = 0;
   logic [1:0] wr_en = 0, page_wr = 0, acc_en = 0, acc_use_imm = 0;
   logic [7:0] wr_target = 0, acc_mode = 0;
   logic [3:0] wr_sel = 0, acc_isel = 0, acc_msel = 0;
   logic [31:0] wr_data = 0;
   logic [15:0] page_data = 0, acc_imm = 0;
   logic [23:0] dm_addr, pm_addr;
   logic dm_addr_valid, pm_addr_valid, set_active;
   logic [7:0] pulses;
   int errors = 0, checks_done = 0;
   always #5 clock = ~clock;
   dag_top i_dut (.clock(clock), .nrst(nrst), .ctx_wr(ctx_wr), .ctx_secondary(ctx_secondary),
      .wr_en(wr_en), .wr_target(wr_target), .wr_sel(wr_sel), .wr_data(wr_data),
      .page_wr(page_wr), .page_data(page_data), .acc_en(acc_en), .acc_mode(acc_mode),
      .acc_isel(acc_isel), .acc_msel(acc_msel), .acc_use_imm(acc_use_imm), .acc_imm(acc_imm),
      .dm_addr(dm_addr), .dm_addr_valid(dm_addr_valid), .pm_addr(pm_addr),
      .pm_addr_valid(pm_addr_valid), .set_active(set_active));
   dag_bus_sink i_sink (.clock(clock), .dm_addr_valid(dm_addr_valid),
      .pm_addr_valid(pm_addr_valid), .pulses(pulses));
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task wr(input int g, input logic [3:0] tgt, input logic [1:0] sel, input logic [15:0] d);
      @(negedge clock);
      wr_en[g] = 1;
      wr_target[4*g+:4] = tgt;
      wr_sel[2*g+:2] = sel;
      wr_data[16*g+:16] = d;
      @(negedge clock);
      wr_en = 0;
   endtask
   task page(input int g, input logic [7:0] p);
      @(negedge clock);
      page_wr[g] = 1;
      page_data[8*g+:8] = p;
      @(negedge clock);
      page_wr = 0;
   endtask
   // checks land in the cycle the one-cycle strobe stands
   task acc(input logic [1:0] en, input logic [7:0] md, input logic [3:0] ix,
            input logic [3:0] ms, input logic [1:0] ui, input logic [15:0] imm);
      @(negedge clock);
      ctx_wr = 0;
      acc_en = en;
      acc_mode = md;
      acc_isel = ix;
      acc_msel = ms;
      acc_use_imm = ui;
      acc_imm = imm;
      @(negedge clock);
      acc_en = 0;
   endtask
   task t_modes;
      page(0, 8'h5A);
      wr(0, dag_pkg::dag_wr_index, 0, 16'h0100);
      wr(0, dag_pkg::dag_wr_modify, 0, 16'h0010);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_post}, 0, 0, 0, 0);
      chk(dm_addr, 24'h5A0100);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_pre}, 0, 0, 0, 0);
      chk(dm_addr, 24'h5A0120);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_pre_noupd}, 0, 0, 2'h1, 16'h00FD);
      chk(dm_addr, 24'h5A011D);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_post}, 0, 0, 0, 0);
      chk(dm_addr, 24'h5A0120);
   endtask
   // pointer 3 with modify 2 must not disturb pointer 0
   task t_regs;
      wr(0, dag_pkg::dag_wr_index, 3, 16'h0200);
      wr(0, dag_pkg::dag_wr_modify, 2, 16'hFFFE);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_post}, 4'h3, 4'h2, 0, 0);
      chk(dm_addr, 24'h5A0200);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_pre}, 4'h3, 4'h2, 0, 0);
      chk(dm_addr, 24'h5A01FC);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_pre_noupd}, 0, 4'h2, 2'h1, 0);
      chk(dm_addr, 24'h5A0130);
   endtask
   task t_circ;
      page(1, 8'hFF);
      wr(1, dag_pkg::dag_wr_index, 0, 16'h00F8);
      wr(1, dag_pkg::dag_wr_base, 0, 16'h00F0);
      wr(1, dag_pkg::dag_wr_length, 0, 16'h0010);
      wr(1, dag_pkg::dag_wr_modify, 0, 16'h0004);
      acc(2'h2, {dag_pkg::dag_mode_post, 4'h8}, 0, 0, 0, 0);
      chk(pm_addr, 24'hFF00F8);
      acc(2'h2, {dag_pkg::dag_mode_post, 4'h8}, 0, 0, 0, 0);
      acc(2'h2, {dag_pkg::dag_mode_post, 4'h8}, 0, 0, 0, 0);
      chk(pm_addr, 24'hFF00F0);
      acc(2'h2, {dag_pkg::dag_mode_pre, 4'h8}, 0, 0, 2'h2, 16'hF800);
      chk(pm_addr, 24'hFF00FC);
      // pointer 1 steps below a base of zero and must fold back, page bits untouched
      wr(1, dag_pkg::dag_wr_index, 1, 16'h0002);
      wr(1, dag_pkg::dag_wr_base, 1, 16'h0000);
      wr(1, dag_pkg::dag_wr_length, 1, 16'h0010);
      wr(1, dag_pkg::dag_wr_modify, 1, 16'hFFFC);
      acc(2'h2, {dag_pkg::dag_mode_post, 4'h8}, 4'h4, 4'h4, 0, 0);
      chk(pm_addr, 24'hFF0002);
      acc(2'h2, {dag_pkg::dag_mode_post, 4'h8}, 4'h4, 4'h4, 0, 0);
      chk(pm_addr, 24'hFF000E);
   endtask
   task t_ctx;
      @(negedge clock);
      ctx_wr = 1;
      ctx_secondary = 1;
      acc(2'h1, {4'h8, dag_pkg::dag_mode_post}, 0, 0, 0, 0);
      chk(dm_addr, 24'h000000);
      chk({23'h0, set_active}, 24'h000001);
      page(0, 8'h33);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_post}, 0, 0, 0, 0);
      chk(dm_addr, 24'h330000);
      acc(2'h1, {4'h8, dag_pkg::dag_mode_none}, 0, 0, 0, 0);
      chk({23'h0, dm_addr_valid}, 24'h000000);
      @(negedge clock);
      ctx_wr = 1;
      ctx_secondary = 0;
      acc(2'h3, {dag_pkg::dag_mode_pre_noupd, dag_pkg::dag_mode_pre_noupd}, 0, 0, 2'h2, 0);
      chk(dm_addr, 24'h5A0140);
      chk(pm_addr, 24'hFF00FC);
      chk({22'h0, dm_addr_valid, pm_addr_valid}, 24'h000003);
   endtask
   // reset in mid-run with the secondary set active must clear set choice and registers
   task t_reset;
      @(negedge clock);
      ctx_wr = 1;
      ctx_secondary = 1;
      @(negedge clock);
      ctx_wr = 0;
      nrst = 0;
      repeat (2) @(negedge clock);
      nrst = 1;
      chk({23'h0, set_active}, 24'h000000);
      acc(2'h3, {dag_pkg::dag_mode_post, dag_pkg::dag_mode_post}, 0, 0, 0, 0);
      chk(dm_addr, 24'h000000);
      chk(pm_addr, 24'h000000);
   endtask
   initial begin
      #50000;
      errors++;
      conclude();
   end
   initial begin
      repeat (20) @(negedge clock);
      nrst = 1;
      t_modes();
      t_regs();
      t_circ();
      t_ctx();
      t_reset();
      @(negedge clock);
      chk({16'h0, pulses}, 24'h000013);
      conclude();
   end
endmodule
